// >>> pkg/cscs_defs.svh
// status codes, limits and field positions for the command status checker
`ifndef CSCS_DEFS_SVH
`define CSCS_DEFS_SVH

`define CSCS_ST_GOOD 8'h00
`define CSCS_ST_QFULL 8'h01
`define CSCS_ST_QINIT_ERR 8'h02
`define CSCS_ST_QNUM_ERR 8'h05
`define CSCS_ST_QALREADY 8'h06
`define CSCS_ST_QUNINIT 8'h07
`define CSCS_ST_QMODE 8'h08
`define CSCS_ST_CMD_UNAVAIL 8'h09
`define CSCS_ST_RSVD 8'h10
`define CSCS_ST_PORT1 8'h12
`define CSCS_ST_OWN_ID 8'h13
`define CSCS_ST_BUS_RESET 8'h14
`define CSCS_ST_ABORT_RESET 8'h15
`define CSCS_ST_PAGE 8'h16
`define CSCS_ST_TAG_ZERO 8'h17
`define CSCS_ST_TAG_BUSY 8'h18
`define CSCS_ST_VME_DATA 8'h20
`define CSCS_ST_VME_FETCH 8'h26
`define CSCS_ST_VME_POST 8'h28
`define CSCS_ST_VME_SG 8'h2C
`define CSCS_ST_SG_COUNT 8'h2E
`define CSCS_ST_SEL_TMO 8'h30
`define CSCS_ST_DISC_TMO 8'h31
`define CSCS_ST_XFER_CNT 8'h34
`define CSCS_ST_PARITY 8'h35
`define CSCS_ST_CDB_LEN 8'h38
`define CSCS_ST_WIDE_ID 8'h39
`define CSCS_ST_SG_ZERO 8'h40
`define CSCS_ST_FLUSH_ERR 8'h80
`define CSCS_ST_FLUSH_CMD 8'h81
`define CSCS_ST_CNT_EXH 8'h83
`define CSCS_ST_DIR_ERR 8'h84

`define CSCS_QMAX_STD 8'h0E
`define CSCS_QMAX_WIDE 8'hFF
`define CSCS_ID_MAX 4'h7
`define CSCS_SG_MAX 9'h100
`define CSCS_CDB_MAX 5'h18

// register offsets
`define CSCS_OFF_CTRL 8'h00
`define CSCS_OFF_CMD 8'h04
`define CSCS_OFF_CMD2 8'h08
`define CSCS_OFF_EXEC 8'h0C
`define CSCS_OFF_QCTL 8'h10
`define CSCS_OFF_RESP 8'h14
`define CSCS_OFF_XFER 8'h18
`define CSCS_OFF_QSTAT 8'h1C
// control bit positions and control reset value
`define CSCS_CTRL_WIDE 0
`define CSCS_CTRL_PORT1 1
`define CSCS_CTRL_QSTART 2
`define CSCS_CTRL_BUSRST 3
`define CSCS_CTRL_ABORTACK 4
`define CSCS_CTRL_OWNID 8
`define CSCS_CTRL_RESET 32'h0000_0000

`endif

// >>> pkg/cscs_pkg.sv
// types for the command status checker
package cscs_pkg;

    // command codes handled by the checker
    typedef enum logic [3:0] {
        CSCS_OP_IO = 4'b0000,
        CSCS_OP_INIT_CTRL = 4'b0001,
        CSCS_OP_INIT_QUEUE = 4'b0010,
        CSCS_OP_FLUSH = 4'b0011,
        CSCS_OP_TAG_SEARCH = 4'b0100,
        CSCS_OP_USER_CDB = 4'b0101
    } cscs_op_e;

    // one parameter block as presented for checking
    typedef struct packed {
        logic [7:0] queue;
        logic [3:0] opcode;
        logic reinit;
        logic port1;
        logic rsvd_nz;
        logic [3:0] target;
        logic [15:0] tag;
        logic [15:0] page;
        logic [8:0] sg_count;
        logic sg_zero_len;
        logic [4:0] cdb_len;
    } cscs_cmd_s;

    // execution outcome flags from the phase engine
    typedef struct packed {
        logic vme_data;
        logic vme_fetch;
        logic vme_post;
        logic vme_sg;
        logic sel_tmo;
        logic disc_tmo;
        logic parity;
        logic bus_reset;
        logic cnt_exh;
        logic dir_err;
        logic tag_busy;
        logic [23:0] moved;
        logic [7:0] passthru;
    } cscs_exec_s;

    // response as posted
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] passback;
        logic [23:0] length;
    } cscs_resp_s;

    typedef enum logic [1:0] {
        CSCS_IDLE = 2'b00,
        CSCS_RUN = 2'b01
    } cscs_state_e;

endpackage : cscs_pkg

// >>> core/cscs_checker.sv
// command status checker with axi4-lite register access
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cscs_defs.svh"

module cscs_checker #(
    parameter int QDEPTH = 4,
    parameter bit DAUGHTER = 1'b0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic resp_valid
);
    import cscs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [31:0] ctrl;           // wide, port1 flag, start, bus reset, own id
    cscs_cmd_s cmd;              // pending parameter block
    cscs_exec_s ex;              // outcome flags from the execution side
    logic [23:0] max_count;      // requested maximum transfer count
    logic ctrl_init;             // controller init seen
    logic [255:0] q_init;        // per queue initialised
    logic [255:0] q_abort;       // per queue abort enable
    logic [255:0] q_flushing;    // per queue flush on error active
    logic [7:0] q_active [0:255]; // entries outstanding per queue
    cscs_resp_s resp;            // last response
    cscs_state_e state;
    logic qmode_err;             // start set before controller init

    ////////////////////////////////////////////////////////////////////////
    // axi write channel: take address and data in either order
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_bresp = 2'b00;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'b00;

    // byte lane merge, used for the control register only
    function automatic logic [31:0] cscs_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction : cscs_merge

    wire wr_ctrl = do_write && (aw_addr == `CSCS_OFF_CTRL);
    wire wr_cmd = do_write && (aw_addr == `CSCS_OFF_CMD);
    wire wr_cmd2 = do_write && (aw_addr == `CSCS_OFF_CMD2);
    wire wr_exec = do_write && (aw_addr == `CSCS_OFF_EXEC);
    wire wr_qctl = do_write && (aw_addr == `CSCS_OFF_QCTL);
    wire [31:0] wv = w_data;

    // address and data capture, response after both
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status selection, first match wins
    wire wide = ctrl[`CSCS_CTRL_WIDE];
    wire [3:0] own_id = ctrl[`CSCS_CTRL_OWNID +: 4];
    wire [7:0] qmax = wide ? `CSCS_QMAX_WIDE : `CSCS_QMAX_STD;
    wire q_range_bad = cmd.queue > qmax;
    wire q_is_init = q_init[cmd.queue];
    wire q_full = q_active[cmd.queue] >= 8'(QDEPTH);
    wire op_known = cmd.opcode <= 4'(CSCS_OP_USER_CDB);
    wire op_is_io = (cmd.opcode == 4'(CSCS_OP_IO)) || (cmd.opcode == 4'(CSCS_OP_USER_CDB));
    logic [7:0] pre_status;      // status known before execution

    always_comb
    begin
        pre_status = `CSCS_ST_GOOD;
        if (q_range_bad)
            pre_status = `CSCS_ST_QNUM_ERR;
        else if (qmode_err)
            pre_status = `CSCS_ST_QMODE;
        else if (q_flushing[cmd.queue] && cmd.opcode != 4'(CSCS_OP_FLUSH))
            pre_status = `CSCS_ST_FLUSH_ERR;
        else if (cmd.opcode == 4'(CSCS_OP_INIT_QUEUE) && q_is_init && !cmd.reinit)
            pre_status = `CSCS_ST_QALREADY;
        else if (op_is_io && !q_is_init && cmd.queue != 8'h00)
            pre_status = `CSCS_ST_QINIT_ERR;
        // control ops to queue lacking parameters
        else if ((cmd.opcode == 4'(CSCS_OP_TAG_SEARCH) || cmd.opcode == 4'(CSCS_OP_FLUSH))
                 && !q_is_init && cmd.queue != 8'h00)
            pre_status = `CSCS_ST_QUNINIT;
        else if (q_full)
            pre_status = `CSCS_ST_QFULL;
        else if (!op_known)
            pre_status = `CSCS_ST_CMD_UNAVAIL;
        else if (cmd.rsvd_nz)
            pre_status = `CSCS_ST_RSVD;
        else if (cmd.port1 && !DAUGHTER)
            pre_status = `CSCS_ST_PORT1;
        else if (cmd.opcode == 4'(CSCS_OP_INIT_CTRL) && cmd.page != 16'h0000)
            pre_status = `CSCS_ST_PAGE;
        else if (cmd.opcode == 4'(CSCS_OP_TAG_SEARCH) && cmd.tag == 16'h0000)
            pre_status = `CSCS_ST_TAG_ZERO;
        else if (op_is_io && cmd.target > `CSCS_ID_MAX)
            pre_status = `CSCS_ST_WIDE_ID;
        else if (op_is_io && cmd.target == own_id)
            pre_status = `CSCS_ST_OWN_ID;
        else if (cmd.opcode == 4'(CSCS_OP_USER_CDB) && (cmd.cdb_len == 5'h00 || cmd.cdb_len > `CSCS_CDB_MAX))
            pre_status = `CSCS_ST_CDB_LEN;
        // sg count range and zero element
        else if (op_is_io && (cmd.sg_count == 9'h000 || cmd.sg_count > `CSCS_SG_MAX))
            pre_status = `CSCS_ST_SG_COUNT;
        else if (op_is_io && cmd.sg_zero_len)
            pre_status = `CSCS_ST_SG_ZERO;
        else if (op_is_io && ctrl[`CSCS_CTRL_BUSRST])
            pre_status = `CSCS_ST_BUS_RESET;
        else if (cmd.opcode == 4'(CSCS_OP_FLUSH))
            pre_status = `CSCS_ST_FLUSH_CMD;
    end

    // execution outcome, only when checks passed
    logic [7:0] exec_status;
    always_comb
    begin
        exec_status = `CSCS_ST_GOOD;
        if (ex.vme_fetch)
            exec_status = `CSCS_ST_VME_FETCH;
        else if (ex.vme_sg)
            exec_status = `CSCS_ST_VME_SG;
        else if (ex.vme_data)
            exec_status = `CSCS_ST_VME_DATA;
        else if (ex.vme_post)
            exec_status = `CSCS_ST_VME_POST;
        else if (ex.bus_reset)
            exec_status = `CSCS_ST_ABORT_RESET;
        else if (ex.sel_tmo)
            exec_status = `CSCS_ST_SEL_TMO;
        else if (ex.disc_tmo)
            exec_status = `CSCS_ST_DISC_TMO;
        else if (ex.parity)
            exec_status = `CSCS_ST_PARITY;
        else if (ex.cnt_exh)
            exec_status = `CSCS_ST_CNT_EXH;
        else if (ex.dir_err)
            exec_status = `CSCS_ST_DIR_ERR;
        else if (ex.tag_busy && cmd.opcode == 4'(CSCS_OP_TAG_SEARCH))
            exec_status = `CSCS_ST_TAG_BUSY;
        else if (op_is_io && ex.moved != max_count)
            exec_status = `CSCS_ST_XFER_CNT;
    end

    wire run_ok = (pre_status == `CSCS_ST_GOOD);
    wire [7:0] qsel = cmd.queue;
    wire q_done = wr_exec && state == CSCS_RUN;

    ////////////////////////////////////////////////////////////////////////
    // command flow: submit via cmd2 write, finish via exec write
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ctrl <= `CSCS_CTRL_RESET;
            cmd <= '0;
            ex <= '0;
            max_count <= 24'h000000;
            ctrl_init <= 1'b0;
            qmode_err <= 1'b0;
            q_init <= '0;
            q_abort <= '0;
            q_flushing <= '0;
            resp <= '0;
            state <= CSCS_IDLE;
            resp_valid <= 1'b0;
        end
        else
        begin
            resp_valid <= 1'b0;
            if (wr_ctrl)
            begin
                ctrl <= cscs_merge(ctrl, wv, w_strb);
                // start before init flags error; clearing start clears it
                // a sticky flag would refuse every later command, controller init included
                qmode_err <= wv[`CSCS_CTRL_QSTART] && !ctrl_init;
                if (wv[`CSCS_CTRL_ABORTACK])
                    q_flushing <= '0;
            end
            if (wr_cmd)
            begin
                cmd.queue <= wv[7:0];
                cmd.opcode <= wv[11:8];
                cmd.reinit <= wv[12];
                cmd.port1 <= wv[13];
                cmd.rsvd_nz <= wv[14];
                cmd.target <= wv[19:16];
                cmd.sg_count <= wv[28:20];
                cmd.sg_zero_len <= wv[29];
                q_abort[wv[7:0]] <= wv[30] ? 1'b1 : q_abort[wv[7:0]];
            end
            if (wr_qctl)
                max_count <= wv[23:0];
            if (wr_cmd2 && state == CSCS_IDLE)
            begin
                cmd.tag <= wv[15:0];
                cmd.page <= {11'h000, wv[20:16]};
                cmd.cdb_len <= wv[25:21];
                state <= CSCS_RUN;
            end
            else if (state == CSCS_RUN && !run_ok)
            begin
                // rejected blocks go straight to the response
                resp.status <= pre_status;
                resp.passback <= 8'h00;
                resp.length <= 24'h000000;
                resp_valid <= 1'b1;
                state <= CSCS_IDLE;
                if (pre_status == `CSCS_ST_FLUSH_CMD)
                    q_flushing[qsel] <= 1'b0;
            end
            else if (q_done)
            begin
                ex <= cscs_exec_s'({wv[31:21], 24'h000000, 8'h00});
                resp.status <= exec_status;
                resp.passback <= ex.passthru;
                resp.length <= ex.moved;
                resp_valid <= 1'b1;
                state <= CSCS_IDLE;
                if (cmd.opcode == 4'(CSCS_OP_INIT_CTRL))
                    ctrl_init <= 1'b1;
                if (cmd.opcode == 4'(CSCS_OP_INIT_QUEUE))
                    q_init[qsel] <= 1'b1;
                // error other than transfer count on abort queue starts flush
                if (exec_status != `CSCS_ST_GOOD && exec_status != `CSCS_ST_XFER_CNT && q_abort[qsel])
                    q_flushing[qsel] <= 1'b1;
            end
            else if (wr_exec)
            begin
                ex.vme_data <= wv[31];
                ex.vme_fetch <= wv[30];
                ex.vme_post <= wv[29];
                ex.vme_sg <= wv[28];
                ex.sel_tmo <= wv[27];
                ex.disc_tmo <= wv[26];
                ex.parity <= wv[25];
                ex.bus_reset <= wv[24];
                ex.cnt_exh <= wv[23];
                ex.dir_err <= wv[22];
                ex.tag_busy <= wv[21];
                ex.moved <= {8'h00, wv[15:0]};
                ex.passthru <= wv[7:0];
            end
        end
    end

    // occupancy per queue: admission sets an empty queue to one, completion or flush frees
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < 256; i++)
                q_active[i] <= 8'h00;
        end
        else if (state == CSCS_RUN && run_ok && q_active[qsel] == 8'h00 && !q_done)
            q_active[qsel] <= 8'h01;
        else if (q_done || (state == CSCS_RUN && pre_status == `CSCS_ST_FLUSH_CMD))
            q_active[qsel] <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel; unmapped reads return zero with okay
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == `CSCS_OFF_CTRL)
                s_axi_rdata <= ctrl;
            else if (s_axi_araddr == `CSCS_OFF_RESP)
                s_axi_rdata <= {8'h00, 8'h00, resp.passback, resp.status};
            else if (s_axi_araddr == `CSCS_OFF_XFER)
                s_axi_rdata <= {8'h00, resp.length};
            else if (s_axi_araddr == `CSCS_OFF_QSTAT)
                s_axi_rdata <= {28'h0000000, qmode_err, ctrl_init, q_flushing[qsel], state == CSCS_RUN};
            else if (s_axi_araddr == `CSCS_OFF_QCTL)
                s_axi_rdata <= {8'h00, max_count};
            else
                s_axi_rdata <= 32'h0000_0000;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule : cscs_checker

// >>> verif/cscs_port_chk.sv
// port assertions for the command status checker
`timescale 1ns/1ps
module cscs_port_chk (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic resp_valid
);
    // one domain, so clock and reset are given once
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    a_resp_one_pulse: assert property (resp_valid |=> !resp_valid)
        else $error("response strobe longer than one cycle");
    a_write_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
        else $error("write response not okay");
    a_read_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00)
        else $error("read response not okay");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_idle_after_reset: assert property ($fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid && !resp_valid)
        else $error("outputs busy after reset");
endmodule : cscs_port_chk

bind cscs_checker cscs_port_chk cscs_port_chk_i (.core_clk, .reset, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .resp_valid);

// >>> verif/cscs_engine_model.sv
// outcome word of the phase engine and dma side for one command
`timescale 1ns/1ps
module cscs_engine_model (
    input wire logic [3:0] fault,
    input wire logic [15:0] moved,
    output logic [31:0] exec_word
);
    logic [10:0] flag_bits; // one fault flag, 1 = vme data .. 11 = tag busy
    assign flag_bits = (fault >= 4'h1 && fault <= 4'hB) ? (11'h400 >> (fault - 4'h1)) : 11'h000;
    // fault 12 moves one unit off the asked count
    assign exec_word = {flag_bits, 5'h00, (fault == 4'hC) ? (moved ^ 16'h0001) : moved};
endmodule : cscs_engine_model

// >>> verif/cscs_checker_bench.sv
// self-checking bench for the command status checker
`timescale 1ns/1ps
module cscs_checker_bench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1; // held high: every answer is taken at once
    logic s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, resp_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, ew;
    logic [3:0] flt = 4'h0;
    logic [15:0] mx = 16'h1000;
    int resp_count = 0; // response strobes seen so far
    logic [31:0] exp_q [$]; // {compare mask, expected value}
    logic [7:0] fcode [1:11] = '{8'h20, 8'h26, 8'h28, 8'h2C, 8'h30, 8'h31, 8'h35, 8'h15, 8'h83, 8'h84, 8'h18};
    localparam logic [31:0] C2 = 32'h0020_0001; // tag 1, page 0, cdb length 1
    int mismatches = 0;
    int checks_done = 0;
    int tn = 0;
    cscs_checker #(.DAUGHTER(1'b0)) cscs_checker_i (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .resp_valid);
    cscs_engine_model cscs_engine_model_i (.fault(flt), .moved(mx), .exec_word(ew));
    always #25 core_clk = ~core_clk;
    // the strobe lasts one cycle, so count the pulses
    always @(posedge core_clk) if (resp_valid) resp_count <= resp_count + 1;
    ////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want)
        begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    // read data is compared against the oldest note when it appears
    always @(negedge core_clk)
    begin
        if (s_axi_rvalid && exp_q.size() > 0)
        begin
            logic [31:0] e;
            e = exp_q.pop_front();
            check(s_axi_rdata[15:0] & e[31:16], e[15:0]);
        end
    end
    ////////////////////////////////////////////////////////////////
    // ready is sampled mid-cycle, where it has settled, and acted on at the next edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta = 1'b0;
        logic tw = 1'b0;
        logic b = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int n = 0; n < 30 && !b; n++)
        begin
            @(negedge core_clk);
            ta = ta | (s_axi_awvalid & s_axi_awready);
            tw = tw | (s_axi_wvalid & s_axi_wready);
            b = s_axi_bvalid;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        if (!b) begin mismatches++; results(); end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic ta = 1'b0;
        logic r = 1'b0;
        exp_q.push_back(e);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 30 && !r; n++)
        begin
            @(negedge core_clk);
            ta = ta | (s_axi_arvalid & s_axi_arready);
            r = s_axi_rvalid;
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        if (!r) begin mismatches++; results(); end
    endtask : rd
    function automatic logic [31:0] cm(input logic [7:0] q, input logic [3:0] op, input logic [8:0] sg);
        return {3'h0, sg, 4'h0, 4'h0, op, q};
    endfunction : cm
    // one command: control, outcome, count, command words, then the posted status
    task automatic run(input logic [31:0] ctl, input logic [31:0] cmd, input logic [31:0] c2,
        input logic [3:0] f, input logic [7:0] st);
        int c0;
        flt = f;
        wr(8'h00, ctl);
        wr(8'h0C, ew);
        wr(8'h10, {16'h0, mx});
        c0 = resp_count;
        wr(8'h04, cmd);
        wr(8'h08, c2);
        for (int k = 0; k < 4 && resp_count == c0; k++) @(negedge core_clk);
        if (resp_count == c0) wr(8'h0C, ew);
        for (int k = 0; k < 20 && resp_count == c0; k++) @(negedge core_clk);
        if (resp_count == c0) begin mismatches++; results(); end
        check(16'(resp_count - c0), 16'h0001);
        rd(8'h14, {16'h00FF, 8'h00, st});
        tn++;
        $display("test %0d done", tn);
    endtask : run
    ////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h43c51ee6));
        mx = 16'h1000 | 16'($urandom());
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        run(32'h704, cm(0, 1, 1), C2, 0, 8'h08);
        run(32'h700, cm(0, 1, 1), 32'h0021_0001, 0, 8'h16);
        run(32'h700, cm(0, 1, 1), C2, 0, 8'h00);
        run(32'h700, cm(15, 0, 1), C2, 0, 8'h05);
        run(32'h700, cm(1, 2, 1), C2, 0, 8'h00);
        run(32'h700, cm(1, 2, 1), C2, 0, 8'h06);
        run(32'h700, cm(1, 2, 1) | 32'h1000, C2, 0, 8'h00);
        run(32'h700, cm(1, 6, 1), C2, 0, 8'h09);
        run(32'h700, cm(1, 0, 1) | 32'h4000, C2, 0, 8'h10);
        run(32'h700, cm(1, 0, 1) | 32'h2000, C2, 0, 8'h12);
        run(32'h700, cm(1, 0, 1) | 32'h7_0000, C2, 0, 8'h13);
        run(32'h700, cm(1, 0, 1) | 32'h8_0000, C2, 0, 8'h39);
        run(32'h700, cm(1, 4, 1), 32'h0020_0000, 0, 8'h17);
        run(32'h700, cm(1, 0, 0), C2, 0, 8'h2E);
        run(32'h700, cm(1, 0, 257), C2, 0, 8'h2E);
        run(32'h700, cm(1, 0, 256), C2, 0, 8'h00);
        run(32'h700, cm(1, 0, 1) | 32'h2000_0000, C2, 0, 8'h40);
        run(32'h700, cm(1, 5, 1), 32'h0000_0001, 0, 8'h38);
        run(32'h700, cm(1, 5, 1), 32'h0320_0001, 0, 8'h38);
        run(32'h700, cm(1, 5, 1), 32'h0300_0001, 0, 8'h00);
        run(32'h708, cm(1, 0, 1), C2, 0, 8'h14);
        for (int i = 1; i <= 11; i++)
            run(32'h700, cm(1, (i == 11) ? 4'h4 : 4'h0, 1), C2, 4'(i), fcode[i]);
        run(32'h700, cm(1, 0, 1), C2, 4'hC, 8'h34);
        rd(8'h18, {16'hFFFF, mx ^ 16'h0001});
        run(32'h700, cm(1, 0, 1), C2, 0, 8'h00);
        rd(8'h14, {16'hFF00, mx[7:0], 8'h00});
        run(32'h700, cm(2, 2, 1), C2, 0, 8'h00);
        run(32'h700, cm(2, 0, 1) | 32'h4000_0000, C2, 7, 8'h35);
        run(32'h700, cm(2, 0, 1) | 32'h4000_0000, C2, 0, 8'h80);
        run(32'h710, cm(2, 0, 1), C2, 0, 8'h00);
        run(32'h700, cm(2, 3, 1), C2, 0, 8'h81);
        run(32'h701, cm(15, 0, 1), C2, 0, 8'h02);
        run(32'h700, cm(3, 3, 1), C2, 0, 8'h07);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, {16'hFFFF, 16'h0000});
        results();
    end
endmodule : cscs_checker_bench
